// ---- common/wbc_pkg.sv ----
`default_nettype none
package wbc_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int         WAYS       = 32;
  localparam int         SETS       = 16;
  localparam int         LINES      = 512;
  localparam int         LINE_WORDS = 8;
  localparam int         WB_DEPTH   = 8;
  localparam logic [3:0] WB_FULL    = 4'h8;
  localparam logic [2:0] LAST_BEAT  = 3'h7;

  // ----------------------------------------
  // Register map (byte offsets) and fields
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_COP    = 8'h04;
  localparam logic [7:0] OFF_STAT   = 8'h08;
  localparam int         CTRL_MMU   = 0;
  localparam int         CTRL_DC    = 2;
  localparam int         CTRL_WB    = 3;
  localparam int         STAT_OP    = 0;
  localparam int         STAT_BUSY  = 1;
  localparam int         STAT_CNT   = 4;
  localparam logic [1:0] OP_FLUSH_ALL = 2'h1;
  localparam logic [1:0] OP_FLUSH_ONE = 2'h2;
  localparam logic [1:0] OP_CLEAN_ONE = 2'h3;

  typedef enum {S_IDLE, S_EVICT, S_DRAIN, S_FILL, S_WAIT, S_EXT} wbc_state_e;
endpackage
`default_nettype wire

// ---- design/wbc_dcache.sv ----
`default_nettype none
module wbc_dcache
  import wbc_pkg::*;
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  wire logic         core_req,
  input  wire logic         core_we,
  input  wire logic [31:0]  core_vaddr,
  input  wire logic [31:0]  core_paddr,
  input  wire logic [31:0]  core_wdata,
  input  wire logic [3:0]   core_be,
  input  wire logic         core_c,
  input  wire logic         core_b,
  input  wire logic         core_perm_ok,
  input  wire logic         merge_en,
  output logic              core_ack,
  output logic              core_abort,
  output logic [31:0]       core_rdata,
  output logic              mmu_enable,
  output logic              mem_req,
  output logic              mem_we,
  output logic              mem_burst,
  output logic [31:0]       mem_addr,
  output logic [127:0]      mem_wdata,
  output logic [15:0]       mem_strb,
  input  wire logic         mem_ack,
  input  wire logic         mem_abort,
  input  wire logic [31:0]  mem_rdata
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [22:0]           vtag [LINES];
  logic [26:0]           ptag [LINES];
  logic [31:0]           dmem [LINES*LINE_WORDS];
  logic [27:0]           wb_addr [WB_DEPTH];
  logic [127:0]          wb_data [WB_DEPTH];
  logic [15:0]           wb_strb [WB_DEPTH];

  wbc_state_e            state, next_state;
  logic [LINES-1:0]      valid, next_valid, dirty_lo, next_dirty_lo, dirty_hi, next_dirty_hi;
  logic [SETS-1:0][4:0]  rr, next_rr;
  logic [2:0]            head, next_head, tail, next_tail, fill_cnt, next_fill_cnt;
  logic [3:0]            count, next_count;
  logic                  wb_busy, next_wb_busy, last_ok, next_last_ok;
  logic [27:0]           last_addr, next_last_addr;
  logic [8:0]            ev_line, next_ev_line;
  logic                  ev_fill, next_ev_fill;
  logic                  ctrl_dc, next_ctrl_dc, ctrl_wb, next_ctrl_wb, next_mmu;
  logic                  op_pend, next_op_pend;
  logic [1:0]            op_code, next_op_code;
  logic [31:0]           op_addr, next_op_addr;
  logic                  ah_wr, next_ah_wr;
  logic [7:0]            ah_addr, next_ah_addr;
  logic [31:0]           next_hrdata, next_core_rdata, next_mem_addr;
  logic                  next_core_ack, next_core_abort;
  logic                  next_mem_req, next_mem_we, next_mem_burst;
  logic [127:0]          next_mem_wdata;
  logic [15:0]           next_mem_strb;

  // Array write ports, driven from the combinational block
  logic                  dm_we, tag_we, wb_push, wb_merge, push_en;
  logic [11:0]           dm_idx;
  logic [3:0]            dm_be;
  logic [31:0]           dm_wdata;
  logic [8:0]            tag_idx;
  logic [27:0]           push_addr;
  logic [127:0]          push_data;
  logic [15:0]           push_strb;
  logic [143:0]          lane;
  logic [9:0]            hc, oc;
  logic [8:0]            victim;
  logic                  sel;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Search all ways of the set; returns {hit, line}
  function automatic logic [9:0] lookup(input logic [31:0] va);
    logic [9:0] r;
    r = '0;
    for (int w = 0; w < WAYS; w++)
    begin
      if (valid[{5'(w), va[8:5]}] && vtag[{5'(w), va[8:5]}] == va[31:9])
        r = {1'b1, 5'(w), va[8:5]};
    end
    return r;
  endfunction

  // Places a word into its lane of a 16-byte block; returns {strb, data}
  function automatic logic [143:0] place(input logic [1:0] w, input logic [31:0] d, input logic [3:0] be);
    logic [15:0] s;
    s = 16'({12'h000, be} << {w, 2'b00});
    return {s, {4{d}}};
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    next_state = state;  next_valid = valid;  next_dirty_lo = dirty_lo;  next_dirty_hi = dirty_hi;
    next_rr = rr;  next_head = head;  next_tail = tail;  next_fill_cnt = fill_cnt;
    next_wb_busy = wb_busy;  next_last_ok = last_ok;  next_last_addr = last_addr;
    next_ev_line = ev_line;  next_ev_fill = ev_fill;  next_ctrl_dc = ctrl_dc;
    next_ctrl_wb = ctrl_wb;  next_mmu = mmu_enable;  next_op_pend = op_pend;
    next_op_code = op_code;  next_op_addr = op_addr;  next_hrdata = hrdata;
    next_core_rdata = core_rdata;  next_core_ack = 1'b0;  next_core_abort = 1'b0;
    next_mem_req = mem_req;  next_mem_we = mem_we;  next_mem_burst = mem_burst;
    next_mem_addr = mem_addr;  next_mem_wdata = mem_wdata;  next_mem_strb = mem_strb;
    dm_we = 1'b0;  dm_idx = '0;  dm_be = '0;  dm_wdata = '0;  tag_we = 1'b0;  tag_idx = '0;
    wb_push = 1'b0;  wb_merge = 1'b0;  push_addr = '0;  push_data = '0;  push_strb = '0;
    hc = lookup(core_vaddr);
    oc = lookup(op_addr);
    victim = {rr[core_vaddr[8:5]], core_vaddr[8:5]};
    lane = place(core_paddr[3:2], core_wdata, core_be);
    push_en = count != WB_FULL;
    case (state)
      S_IDLE:
      begin
        if (op_pend)
        begin
          next_op_pend = 1'b0;
          case (op_code)
            OP_FLUSH_ALL:
            begin
              next_valid = '0;
              next_dirty_lo = '0;
              next_dirty_hi = '0;
            end
            OP_FLUSH_ONE:
            begin
              if (oc[9])
              begin
                next_valid[oc[8:0]] = 1'b0;
                next_dirty_lo[oc[8:0]] = 1'b0;
                next_dirty_hi[oc[8:0]] = 1'b0;
              end
            end
            OP_CLEAN_ONE:
            begin
              if (oc[9])
              begin
                next_ev_line = oc[8:0];
                next_ev_fill = 1'b0;
                next_state = S_EVICT;
              end
            end
            default: ;
          endcase
        end
        else if (core_req && !core_ack)
        begin
          if (hc[9] && !core_we)
          begin
            next_core_rdata = dmem[{hc[8:0], core_vaddr[4:2]}];
            next_core_ack = 1'b1;
          end
          else if (hc[9])
          begin
            // Permitted store hit stays in the cache, whatever the page attributes
            if (core_perm_ok)
            begin
              dm_we = 1'b1;
              dm_idx = {hc[8:0], core_vaddr[4:2]};
              dm_be = core_be;
              dm_wdata = core_wdata;
              if (core_vaddr[4])
                next_dirty_hi[hc[8:0]] = 1'b1;
              else
                next_dirty_lo[hc[8:0]] = 1'b1;
            end
            next_core_abort = !core_perm_ok;
            next_core_ack = 1'b1;
          end
          else if (!core_we)
          begin
            if (core_c && ctrl_dc)
            begin
              next_ev_line = victim;
              next_ev_fill = 1'b1;
              next_state = S_EVICT;
            end
            else
              next_state = S_WAIT;
          end
          else if (!core_perm_ok)
          begin
            next_core_abort = 1'b1;
            next_core_ack = 1'b1;
          end
          else if (ctrl_wb && core_b)
          begin
            // The entry being issued is never merged into
            if (merge_en && core_c && last_ok && count != 4'h0 && last_addr == core_paddr[31:4]
                && !(wb_busy && head == 3'(tail - 3'h1)))
            begin
              wb_merge = 1'b1;
              push_data = lane[127:0];
              push_strb = lane[143:128];
              next_core_ack = 1'b1;
            end
            else if (push_en)
            begin
              wb_push = 1'b1;
              push_addr = core_paddr[31:4];
              push_data = lane[127:0];
              push_strb = lane[143:128];
              next_last_ok = core_c;
              next_last_addr = core_paddr[31:4];
              next_core_ack = 1'b1;
            end
          end
          else
            next_state = S_WAIT;
        end
      end
      S_EVICT:
      begin
        // One dirty half per cycle, each as its own 16-byte entry
        if (dirty_lo[ev_line] || dirty_hi[ev_line])
        begin
          if (push_en)
          begin
            wb_push = 1'b1;
            next_last_ok = 1'b0;
            if (dirty_lo[ev_line])
            begin
              next_dirty_lo[ev_line] = 1'b0;
              push_addr = {ptag[ev_line], 1'b0};
              push_data = {dmem[{ev_line, 3'h3}], dmem[{ev_line, 3'h2}],
                           dmem[{ev_line, 3'h1}], dmem[{ev_line, 3'h0}]};
            end
            else
            begin
              next_dirty_hi[ev_line] = 1'b0;
              push_addr = {ptag[ev_line], 1'b1};
              push_data = {dmem[{ev_line, 3'h7}], dmem[{ev_line, 3'h6}],
                           dmem[{ev_line, 3'h5}], dmem[{ev_line, 3'h4}]};
            end
            push_strb = 16'hffff;
          end
        end
        else
          next_state = ev_fill ? S_DRAIN : S_IDLE;
      end
      S_DRAIN:
      begin
        // Drain first so a buffered write to the same line cannot be read stale
        if (count == 4'h0 && !wb_busy)
        begin
          next_valid[ev_line] = 1'b0;
          next_mem_req = 1'b1;
          next_mem_we = 1'b0;
          next_mem_burst = 1'b1;
          next_mem_addr = {core_paddr[31:5], 5'h00};
          next_fill_cnt = '0;
          next_state = S_FILL;
        end
      end
      S_FILL:
      begin
        if (mem_ack)
        begin
          dm_we = 1'b1;
          dm_idx = {ev_line, fill_cnt};
          dm_be = 4'hf;
          dm_wdata = mem_rdata;
          next_fill_cnt = 3'(fill_cnt + 3'h1);
          if (fill_cnt == LAST_BEAT)
          begin
            next_mem_req = 1'b0;
            next_mem_burst = 1'b0;
            tag_we = 1'b1;
            tag_idx = ev_line;
            next_valid[ev_line] = 1'b1;
            next_rr[core_vaddr[8:5]] = 5'(rr[core_vaddr[8:5]] + 5'h01);
            next_state = S_IDLE;
          end
        end
      end
      S_WAIT:
      begin
        if (count == 4'h0 && !wb_busy)
        begin
          next_mem_req = 1'b1;
          next_mem_we = core_we;
          next_mem_burst = 1'b0;
          next_mem_addr = core_paddr;
          next_mem_wdata = lane[127:0];
          next_mem_strb = core_we ? lane[143:128] : 16'h0000;
          next_state = S_EXT;
        end
      end
      S_EXT:
      begin
        if (mem_ack)
        begin
          next_mem_req = 1'b0;
          next_core_rdata = core_we ? core_rdata : mem_rdata;
          next_core_abort = mem_abort;
          next_core_ack = 1'b1;
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase

    // ----------------------------------------
    // Write buffer drain, oldest entry first
    // ----------------------------------------
    if (wb_busy && mem_ack)
    begin
      next_mem_req = 1'b0;
      next_wb_busy = 1'b0;
      next_head = 3'(head + 3'h1);
    end
    else if (!wb_busy && !mem_req && count != 4'h0 && !wb_merge && state != S_FILL && state != S_EXT)
    begin
      next_wb_busy = 1'b1;
      next_mem_req = 1'b1;
      next_mem_we = 1'b1;
      next_mem_burst = 1'b0;
      next_mem_addr = {wb_addr[head], 4'h0};
      next_mem_wdata = wb_data[head];
      next_mem_strb = wb_strb[head];
    end
    if (wb_push)
      next_tail = 3'(tail + 3'h1);
    next_count = 4'(count + {3'h0, wb_push} - {3'h0, wb_busy && mem_ack});

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    sel = hsel && htrans[1] && hready;
    next_ah_wr = sel && hwrite;
    next_ah_addr = haddr[7:0];
    if (sel && !hwrite)
    begin
      next_hrdata = '0;
      case (haddr[7:0])
        OFF_CTRL:
        begin
          next_hrdata[CTRL_MMU] = mmu_enable;
          next_hrdata[CTRL_DC] = ctrl_dc;
          next_hrdata[CTRL_WB] = ctrl_wb;
        end
        OFF_STAT:
        begin
          next_hrdata[STAT_OP] = op_pend;
          next_hrdata[STAT_BUSY] = state != S_IDLE;
          next_hrdata[STAT_CNT+:4] = count;
        end
        default: ;
      endcase
    end
    if (ah_wr && ah_addr == OFF_CTRL)
    begin
      next_mmu = hwdata[CTRL_MMU];
      next_ctrl_dc = hwdata[CTRL_DC];
      next_ctrl_wb = hwdata[CTRL_WB];
    end
    if (ah_wr && ah_addr == OFF_COP && !op_pend)
    begin
      next_op_pend = 1'b1;
      next_op_code = hwdata[1:0];
      next_op_addr = {hwdata[31:5], 5'h00};
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= S_IDLE;
      valid <= '0;
      dirty_lo <= '0;
      dirty_hi <= '0;
      rr <= '0;
      head <= '0;
      tail <= '0;
      count <= '0;
      wb_busy <= 1'b0;
      last_ok <= 1'b0;
      last_addr <= '0;
      fill_cnt <= '0;
      ev_line <= '0;
      ev_fill <= 1'b0;
      ctrl_dc <= 1'b0;
      ctrl_wb <= 1'b0;
      mmu_enable <= 1'b0;
      op_pend <= 1'b0;
      op_code <= '0;
      op_addr <= '0;
      ah_wr <= 1'b0;
      ah_addr <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      core_rdata <= '0;
      core_ack <= 1'b0;
      core_abort <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_burst <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
      mem_strb <= '0;
    end
    else
    begin
      state <= next_state;
      valid <= next_valid;
      dirty_lo <= next_dirty_lo;
      dirty_hi <= next_dirty_hi;
      rr <= next_rr;
      head <= next_head;
      tail <= next_tail;
      count <= next_count;
      wb_busy <= next_wb_busy;
      last_ok <= next_last_ok;
      last_addr <= next_last_addr;
      fill_cnt <= next_fill_cnt;
      ev_line <= next_ev_line;
      ev_fill <= next_ev_fill;
      ctrl_dc <= next_ctrl_dc;
      ctrl_wb <= next_ctrl_wb;
      mmu_enable <= next_mmu;
      op_pend <= next_op_pend;
      op_code <= next_op_code;
      op_addr <= next_op_addr;
      ah_wr <= next_ah_wr;
      ah_addr <= next_ah_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      core_rdata <= next_core_rdata;
      core_ack <= next_core_ack;
      core_abort <= next_core_abort;
      mem_req <= next_mem_req;
      mem_we <= next_mem_we;
      mem_burst <= next_mem_burst;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      mem_strb <= next_mem_strb;
    end
  end

  // ----------------------------------------
  // Arrays (no reset; validity lives in the control state)
  // ----------------------------------------
  always_ff @(posedge hclk)
  begin
    for (int b = 0; b < 4; b++)
    begin
      if (dm_we && dm_be[b])
        dmem[dm_idx][8*b+:8] <= dm_wdata[8*b+:8];
    end
    if (tag_we)
    begin
      vtag[tag_idx] <= core_vaddr[31:9];
      ptag[tag_idx] <= core_paddr[31:5];
    end
    if (wb_push)
    begin
      wb_addr[tail] <= push_addr;
      wb_data[tail] <= push_data;
      wb_strb[tail] <= push_strb;
    end
    for (int b = 0; b < 16; b++)
    begin
      if (wb_merge && push_strb[b])
      begin
        wb_data[3'(tail - 3'h1)][8*b+:8] <= push_data[8*b+:8];
        wb_strb[3'(tail - 3'h1)][b] <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/wbc_mem_model.sv ----
`default_nettype none
module wbc_mem_model
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        mem_req,
  input  wire logic        mem_burst,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  slow,
  input  wire logic        abt,
  output var logic         mem_ack,
  output var logic         mem_abort,
  output var logic [31:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] beat;
  logic [3:0] wait_c;
  logic       done;

  initial {mem_ack, mem_abort, mem_rdata} = '0;

  // ----------------------------------------
  // Beat responder
  // ----------------------------------------
  // Idle read data toggles so a stale beat can never look valid
  always @(posedge hclk or negedge hresetn)
  begin
    mem_ack <= 1'b0;
    mem_abort <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!hresetn || !mem_req)
    begin
      beat <= 3'h0;
      wait_c <= slow;
      done <= 1'b0;
    end
    else if (!done && wait_c != 4'h0)
      wait_c <= wait_c - 4'h1;
    else if (!done)
    begin
      mem_ack <= 1'b1;
      mem_abort <= abt;
      mem_rdata <= (mem_addr + {27'h0, beat, 2'h0}) ^ 32'ha5c3_0000;
      beat <= beat + 3'h1;
      wait_c <= slow;
      done <= !mem_burst || beat == 3'h7;
    end
  end
endmodule
`default_nettype wire

// ---- tb/wbc_dcache_chk.sv ----
`default_nettype none
module wbc_dcache_chk
  import wbc_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        core_req,
  input wire logic        core_we,
  input wire logic        core_c,
  input wire logic        core_b,
  input wire logic        core_ack,
  input wire logic        core_abort,
  input wire logic        mmu_enable,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_burst,
  input wire logic [31:0] mem_addr,
  input wire logic [15:0] mem_strb,
  input wire logic        mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] beats;
  logic [3:0] next_beats;

  // ----------------------------------------
  // Beats of the current transfer
  // ----------------------------------------
  always_comb
  begin
    next_beats = beats;
    if (!mem_req)
      next_beats = 4'h0;
    else if (mem_ack)
      next_beats = beats + 4'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      beats <= 4'h0;
    else
      beats <= next_beats;
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_reset;
    $rose(hresetn) |-> !mem_req && !core_ack && !mmu_enable;
  endproperty
  property p_mmu;
    hsel && htrans[1] && hready && hwrite && haddr[7:0] == OFF_CTRL ##1 1'b1
      |=> mmu_enable == $past(hwdata[CTRL_MMU]);
  endproperty
  property p_fill_addr;
    $rose(mem_req) && mem_burst |-> !mem_we && mem_addr[4:0] == 5'h0;
  endproperty
  property p_fill_len;
    $fell(mem_req) && $past(mem_burst) && !$past(mem_we) |-> beats == 4'h8;
  endproperty
  property p_one_beat;
    mem_req && !mem_burst && mem_ack |=> !mem_req;
  endproperty
  property p_stable;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_strb);
  endproperty
  property p_unbuf;
    core_ack && core_req && core_we && !core_b && !core_c && !core_abort |-> $past(mem_ack && mem_we);
  endproperty
  property p_strb;
    mem_req && mem_we |-> mem_strb != 16'h0;
  endproperty

  a_reset: assert property (p_reset) else $error("not idle after reset");
  a_mmu: assert property (p_mmu) else $error("mmu enable wrong");
  a_fill_addr: assert property (p_fill_addr) else $error("fill not line aligned");
  a_fill_len: assert property (p_fill_len) else $error("fill beat count");
  a_one_beat: assert property (p_one_beat) else $error("single transfer overran");
  a_stable: assert property (p_stable) else $error("request changed early");
  a_unbuf: assert property (p_unbuf) else $error("unbuffered ack early");
  a_strb: assert property (p_strb) else $error("empty write");

  c_fill: cover property ($rose(mem_req) && mem_burst);
  c_single: cover property ($rose(mem_req) && !mem_burst && !mem_we);
  c_unbuf: cover property (core_ack && core_we && !core_b);
endmodule
`default_nettype wire

// ---- tb/wbc_dcache_bench.sv ----
`default_nettype none
module wbc_dcache_bench
  import wbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] PA = 32'h4000_0000;
  localparam logic [31:0] K  = 32'ha5c3_0000;
  localparam logic [31:0] A  = 32'h0000_1040;
  localparam logic [31:0] B  = 32'h0000_2000;
  localparam logic [31:0] C  = 32'h0000_2100;
  localparam logic [31:0] U  = 32'h0000_3000;

  logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, abt, merge_en;
  logic         core_req, core_we, core_c, core_b, core_perm_ok, core_ack, core_abort;
  logic         mmu_enable, mem_req, mem_we, mem_burst, mem_ack, mem_abort;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [3:0]   core_be, slow;
  logic [15:0]  mem_strb;
  logic [31:0]  haddr, hwdata, hrdata, core_vaddr, core_paddr, core_wdata, core_rdata;
  logic [31:0]  mem_addr, mem_rdata, r, seed;
  logic [127:0] mem_wdata;
  logic [32:0]  e;
  logic [32:0]  exq[$];
  logic [79:0]  w;
  logic [79:0]  mwq[$];
  int           mismatches, num_checks, n_burst, n_single;

  wbc_dcache dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .core_req, .core_we, .core_vaddr, .core_paddr, .core_wdata, .core_be,
    .core_c, .core_b, .core_perm_ok, .merge_en, .core_ack, .core_abort, .core_rdata, .mmu_enable,
    .mem_req, .mem_we, .mem_burst, .mem_addr, .mem_wdata, .mem_strb, .mem_ack, .mem_abort, .mem_rdata);
  wbc_mem_model mem_u (.hclk, .hresetn, .mem_req, .mem_burst, .mem_addr, .slow, .abt, .mem_ack,
    .mem_abort, .mem_rdata);

  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", hresp, 1'b0);
  endtask

  task automatic ctrl(input logic [31:0] v);
    ahb(1'b1, {24'h0, OFF_CTRL}, v, r);
    @(posedge hclk);
  endtask

  // Read expectations ride in d; a write's d is its data
  task automatic core_op(input logic we, input logic c, input logic b, input logic [31:0] a, input logic [31:0] d);
    exq.push_back({!we, d});
    @(posedge hclk);
    core_req <= 1'b1;
    core_we <= we;
    core_c <= c;
    core_b <= b;
    core_vaddr <= a;
    core_paddr <= a ^ PA;
    core_wdata <= d;
    do @(posedge hclk); while (core_ack !== 1'b1);
    core_req <= 1'b0;
  endtask

  // ----------------------------------------
  // Result watchers
  // ----------------------------------------
  always @(posedge hclk)
  begin
    if (hresetn && core_ack === 1'b1)
    begin
      e = exq.pop_front();
      check("core_abort", core_abort, 1'b0);
      if (e[32])
        check("core_rdata", core_rdata, e[31:0]);
    end
    if (hresetn && mem_req === 1'b1 && mem_ack === 1'b1)
    begin
      if (mem_we)
      begin
        w = mwq.pop_front();
        check("wr_addr", mem_addr, w[31:0]);
        check("wr_strb", {16'h0, mem_strb}, {16'h0, w[47:32]});
        check("wr_data", mem_wdata[31:0], w[79:48]);
      end
      else if (mem_burst)
        n_burst++;
      else
        n_single++;
    end
  end

  initial
  begin
    repeat (60000) @(posedge hclk);
    mismatches++;
    test_done();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, core_req, core_we, core_c, core_b, merge_en, abt} = '0;
    {core_vaddr, core_paddr, core_wdata, slow} = '0;
    hsize = 3'h2;
    core_be = 4'hf;
    core_perm_ok = 1'b1;
    seed = 32'd96979;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, {24'h0, OFF_STAT}, 32'h0, r);
    check("status", r, 32'h0);
    ahb(1'b0, 32'h0000_000c, 32'h0, r);
    check("unmapped", r, 32'h0);
    core_op(1'b0, 1'b1, 1'b1, A, (A ^ PA) ^ K);
    check("no_alloc", n_burst, 0);
    ctrl(32'hd);
    check("mmu_on", mmu_enable, 1'b1);
    core_op(1'b0, 1'b1, 1'b1, A, (A ^ PA) ^ K);
    core_op(1'b0, 1'b0, 1'b1, A + 32'h4, ((A + 32'h4) ^ PA) ^ K);
    check("fill_beats", n_burst, 8);
    check("single_rd", n_single, 1);
    slow <= 4'h6;
    abt <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      r = rnd();
      mwq.push_back({r, 16'h000f << (4 * k), B ^ PA});
      core_op(1'b1, 1'b0, 1'b1, B + 32'(4 * k), r);
    end
    merge_en <= 1'b1;
    r = rnd();
    mwq.push_back({r, 16'h00ff, C ^ PA});
    core_op(1'b1, 1'b1, 1'b1, C, r);
    core_op(1'b1, 1'b1, 1'b1, C + 32'h4, rnd());
    abt <= 1'b0;
    slow <= 4'hf;
    // Ten writes into eight entries: the tail must stall, not drop
    for (int k = 0; k < 10; k++)
    begin
      r = rnd() & 32'h0000_0ff0 | 32'h0000_5000;
      mwq.push_back({r, 16'h000f, r ^ PA});
      core_op(1'b1, 1'b0, 1'b1, r, r);
    end
    while (mwq.size() != 0)
      @(posedge hclk);
    slow <= 4'h0;
    ctrl(32'h5);
    for (int k = 0; k < 2; k++)
    begin
      r = rnd();
      mwq.push_back({r, 16'h000f, (U + 32'(16 * k)) ^ PA});
      core_op(1'b1, 1'b0, k == 0, U + 32'(16 * k), r);
      check("unbuf_done", mwq.size(), 0);
    end
    core_op(1'b1, 1'b1, 1'b0, A + 32'h14, 32'h1234_5678);
    core_op(1'b0, 1'b0, 1'b1, A + 32'h14, 32'h1234_5678);
    mwq.push_back({((A ^ PA) + 32'h10) ^ K, 16'hffff, (A ^ PA) + 32'h10});
    ahb(1'b1, {24'h0, OFF_COP}, {A[31:5], 3'h0, OP_CLEAN_ONE}, r);
    for (int k = 0; k < 40 && mwq.size() != 0; k++)
      ahb(1'b0, {24'h0, OFF_STAT}, 32'h0, r);
    check("clean_wb", mwq.size(), 0);
    ahb(1'b1, {24'h0, OFF_COP}, {30'h0, OP_FLUSH_ALL}, r);
    core_op(1'b0, 1'b0, 1'b1, A, (A ^ PA) ^ K);
    check("flushed", n_single, 2);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("mmu_off", mmu_enable, 1'b0);
    ctrl(32'hd);
    core_op(1'b0, 1'b1, 1'b1, A, (A ^ PA) ^ K);
    check("refill", n_burst, 16);
    check("wr_left", mwq.size(), 0);
    test_done();
  end
endmodule

bind wbc_dcache wbc_dcache_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .core_req, .core_we, .core_c, .core_b, .core_ack, .core_abort, .mmu_enable, .mem_req, .mem_we, .mem_burst,
  .mem_addr, .mem_strb, .mem_ack);
`default_nettype wire
